/* File: hdl/pas_cfg.svh */
`ifndef PAS_CFG_SVH
`define PAS_CFG_SVH

// register map, word index on the plain register port
`define PAS_OFS_CTRL 2'h0
`define PAS_OFS_STAT 2'h1
`define PAS_OFS_MASK 2'h2

// control register fields
`define PAS_FLAG_BIT 7
`define PAS_SRC_HI 6
`define PAS_SRC_LO 4
`define PAS_AC_HI 3
`define PAS_AC_LO 2
`define PAS_BD_HI 1
`define PAS_BD_LO 0

// event status / mask fields
`define PAS_EV_HW 0
`define PAS_EV_SW 1
`define PAS_EV_REL 2

// reset values
`define PAS_CTRL_RST 8'h00
`define PAS_MASK_RST 8'h00
`define PAS_STAT_RST 8'h00
`define PAS_RD_ZERO 8'h00

`endif

/* File: hdl/pas_pkg.sv */
package pas_pkg;

  typedef enum logic [2:0] {
    PAS_SRC_OFF = 3'h0,
    PAS_SRC_C1 = 3'h1,
    PAS_SRC_C2 = 3'h2,
    PAS_SRC_C12 = 3'h3,
    PAS_SRC_X = 3'h4,
    PAS_SRC_XC1 = 3'h5,
    PAS_SRC_XC2 = 3'h6,
    PAS_SRC_XC12 = 3'h7
  } pas_src_sel_t;

  // pin state field codes; any code with the upper bit set floats the pair
  typedef enum logic [1:0] {
    PAS_PIN_LOW = 2'h0,
    PAS_PIN_HIGH = 2'h1
  } pas_pin_code_t;

  typedef enum logic [2:0] {
    PAS_ST_RUN = 3'b001,
    PAS_ST_SHUT = 3'b010,
    PAS_ST_WAIT = 3'b100
  } pas_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } pas_pins_t;

  typedef struct packed {
    logic flag;
    pas_src_sel_t src_sel;
    logic [1:0] ac_state;
    logic [1:0] bd_state;
  } pas_ctrl_t;

  typedef struct packed {
    logic cmp1;
    logic cmp2;
    logic ext;
  } pas_src_t;

endpackage

/* File: hdl/pas_auto_shutdown.sv */
// Behaviour
// - shutdown sources act only while the output unit runs a pwm mode.
// - select 000 disables; 001, 010, 011 pick comparator 1, 2, either.
// - select 100 to 111 add external irq zero, alone or with comparators.
// - a/c field 00 drives low, 01 high, upper bit set floats pins.
// - b/d field 00 drives low, 01 high, upper bit set floats pins.
// - on shutdown the chosen levels replace the normal pwm values.
// - shutdown gates the outputs combinationally, without waiting for a clock.
// - shutdown still present at period start suppresses that whole period.
// - hardware sets flag bit 7 on an event; only software clears it.
// - outputs stay shut down until the first period start after software clears the flag.
// - software writing 1 to the flag enters shutdown like hardware.
`include "pas_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pas_auto_shutdown
  import pas_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pwm engine side, same clock
  input wire logic pwm_mode_i,
  input wire logic period_start_i,
  input wire pas_pins_t pwm_level_i,
  input wire pas_pins_t pwm_oe_i,
  input wire logic external_irq_zero_enable_i,
  // asynchronous shutdown sources
  input wire logic cmp1_i,
  input wire logic cmp2_i,
  input wire logic external_irq_zero_i,
  // bridge pins
  output pas_pins_t bridge_out_o,
  output pas_pins_t bridge_oe_o,
  output logic shutdown_active_o,
  // interrupt
  output logic irq_o
);

  if (ADDR_W < 2) begin : g_chk_addr
    $error("ADDR_W must be at least 2");
  end
  if (SYNC_STAGES < 2) begin : g_chk_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // source hit decode, shared by raw and synchronised paths
  function automatic logic src_hit(input pas_src_sel_t sel, input pas_src_t s);
    logic hit;
    hit = 1'b0;
    if (sel[0]) begin
      hit = hit | s.cmp1;
    end
    if (sel[1]) begin
      hit = hit | s.cmp2;
    end
    if (sel[2]) begin
      hit = hit | s.ext;
    end
    return hit;
  endfunction

  // pin pair decode: {drive enable, level}
  function automatic logic [1:0] pin_state(input logic [1:0] code);
    logic [1:0] r;
    r = 2'b00;
    case (code)
      PAS_PIN_LOW: r = 2'b10;
      PAS_PIN_HIGH: r = 2'b11;
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  // synchronisers for the three source pins
  pas_src_t src_raw;
  pas_src_t src_sync;
  logic [SYNC_STAGES-1:0] sync_q [3];

  assign src_raw.cmp1 = cmp1_i;
  assign src_raw.cmp2 = cmp2_i;
  // ignored unless its interrupt enable is set
  assign src_raw.ext = external_irq_zero_i & external_irq_zero_enable_i;

  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic pin;
    logic [SYNC_STAGES-1:0] sync_d;
    assign pin = (i == 0) ? cmp1_i : ((i == 1) ? cmp2_i : external_irq_zero_i);
    always_comb begin
      sync_d = {sync_q[i][SYNC_STAGES-2:0], pin};
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        sync_q[i] <= '0;
      end else begin
        sync_q[i] <= sync_d;
      end
    end
  end

  assign src_sync.cmp1 = sync_q[0][SYNC_STAGES-1];
  assign src_sync.cmp2 = sync_q[1][SYNC_STAGES-1];
  // enable comes from logic on this clock
  assign src_sync.ext = sync_q[2][SYNC_STAGES-1] & external_irq_zero_enable_i;

  // register state
  pas_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic hw_event;
  logic wr_ctrl, wr_mask, rd_stat;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_W'(`PAS_OFS_CTRL));
  assign wr_mask = reg_wr_i && (reg_addr_i == ADDR_W'(`PAS_OFS_MASK));
  assign rd_stat = reg_rd_i && (reg_addr_i == ADDR_W'(`PAS_OFS_STAT));

  // sources only count in a pwm mode
  assign hw_event = pwm_mode_i && src_hit(ctrl_q.src_sel, src_sync);

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = `PAS_RD_ZERO;
    if (wr_ctrl) begin
      // writing 1 enters shutdown, 0 clears
      ctrl_d = pas_ctrl_t'(reg_wdata_i);
    end
    // hardware only ever sets the flag
    // set wins over a clearing write
    if (hw_event) begin
      ctrl_d.flag = 1'b1;
    end
    if (wr_mask) begin
      mask_d = reg_wdata_i;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_W'(`PAS_OFS_CTRL): rdata_d = 8'(ctrl_q);
        ADDR_W'(`PAS_OFS_STAT): rdata_d = stat_q;
        ADDR_W'(`PAS_OFS_MASK): rdata_d = mask_q;
        default: rdata_d = `PAS_RD_ZERO;
      endcase
    end
    // read clears status; new events win
    if (rd_stat) begin
      stat_d = `PAS_STAT_RST;
    end
    if (hw_event && !ctrl_q.flag) begin
      stat_d[`PAS_EV_HW] = 1'b1;
    end
    if (wr_ctrl && reg_wdata_i[`PAS_FLAG_BIT] && !ctrl_q.flag) begin
      stat_d[`PAS_EV_SW] = 1'b1;
    end
    if (ctrl_q.flag && !ctrl_d.flag) begin
      stat_d[`PAS_EV_REL] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= pas_ctrl_t'(`PAS_CTRL_RST);
      stat_q <= `PAS_STAT_RST;
      mask_q <= `PAS_MASK_RST;
      rdata_q <= `PAS_RD_ZERO;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;

  // period suppression state
  pas_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PAS_ST_RUN: begin
        if (ctrl_d.flag) begin
          state_d = PAS_ST_SHUT;
        end
      end
      PAS_ST_SHUT: begin
        // held until software clears the flag
        if (!ctrl_d.flag) begin
          state_d = PAS_ST_WAIT;
        end
      end
      PAS_ST_WAIT: begin
        if (ctrl_d.flag) begin
          state_d = PAS_ST_SHUT;
        end else if (period_start_i && !hw_event) begin
          state_d = PAS_ST_RUN;
        end
      end
      default: state_d = PAS_ST_SHUT;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= PAS_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // output gating; raw source term keeps the cut-off clockless
  logic shut;
  logic [1:0] ac_sel, bd_sel;
  pas_pins_t out_lvl, out_oe;

  // immediate gating through the raw sources
  // only while a pwm mode is selected
  assign shut = pwm_mode_i &&
                (ctrl_q.flag || (state_q != PAS_ST_RUN) || src_hit(ctrl_q.src_sel, src_raw));
  assign ac_sel = pin_state(ctrl_q.ac_state);
  assign bd_sel = pin_state(ctrl_q.bd_state);

  always_comb begin
    out_lvl = pwm_level_i;
    out_oe = pwm_oe_i;
    if (shut) begin
      out_lvl.a = ac_sel[0];
      out_lvl.c = ac_sel[0];
      out_oe.a = ac_sel[1];
      out_oe.c = ac_sel[1];
      out_lvl.b = bd_sel[0];
      out_lvl.d = bd_sel[0];
      out_oe.b = bd_sel[1];
      out_oe.d = bd_sel[1];
    end
  end

  assign bridge_out_o = out_lvl;
  assign bridge_oe_o = out_oe;
  assign shutdown_active_o = shut;

endmodule

`default_nettype wire

/* File: dv/pas_auto_shutdown_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pas_sva
  import pas_pkg::*;
#(parameter int ADDR_W = 2) (
  // clock, reset, register port
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pwm side and sources
  input wire logic pwm_mode_i,
  input wire logic period_start_i,
  input wire pas_pins_t pwm_level_i,
  input wire pas_pins_t pwm_oe_i,
  input wire logic external_irq_zero_enable_i,
  input wire logic cmp1_i,
  input wire logic external_irq_zero_i,
  // pins
  input wire pas_pins_t bridge_out_o,
  input wire pas_pins_t bridge_oe_o,
  input wire logic shutdown_active_o
);
  // shadow of the software-only control bits
  logic [6:0] cfg_q;
  logic [6:0] cfg_d;
  logic wr_ctrl;
  always_comb begin
    wr_ctrl = reg_wr_i && (reg_addr_i == '0);
    cfg_d = wr_ctrl ? reg_wdata_i[6:0] : cfg_q;
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= 7'h00;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_mode;
    !pwm_mode_i |-> !shutdown_active_o;
  endproperty
  a_mode: assert property (p_mode) else $error("override outside pwm mode");
  property p_cmp;
    pwm_mode_i && cfg_q[4] && cmp1_i |-> shutdown_active_o;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator ignored");
  property p_ext;
    pwm_mode_i && cfg_q[6] && external_irq_zero_enable_i && external_irq_zero_i
      |-> shutdown_active_o;
  endproperty
  a_ext: assert property (p_ext) else $error("external source ignored");
  property p_ac;
    shutdown_active_o |-> bridge_oe_o.a == !cfg_q[3] && bridge_oe_o.c == !cfg_q[3]
      && (cfg_q[3] || bridge_out_o.a == cfg_q[2]);
  endproperty
  a_ac: assert property (p_ac) else $error("a/c shutdown level wrong");
  property p_bd;
    shutdown_active_o |-> bridge_oe_o.b == !cfg_q[1] && bridge_oe_o.d == !cfg_q[1]
      && (cfg_q[1] || bridge_out_o.d == cfg_q[0]);
  endproperty
  a_bd: assert property (p_bd) else $error("b/d shutdown level wrong");
  property p_pass;
    !shutdown_active_o |-> bridge_out_o == pwm_level_i && bridge_oe_o == pwm_oe_i;
  endproperty
  a_pass: assert property (p_pass) else $error("normal pins not passed");
  property p_sw;
    wr_ctrl && reg_wdata_i[7] && pwm_mode_i |=> shutdown_active_o || !pwm_mode_i;
  endproperty
  a_sw: assert property (p_sw) else $error("software entry missed");
  property p_rel;
    $fell(shutdown_active_o) && $past(pwm_mode_i) && pwm_mode_i |-> $past(period_start_i);
  endproperty
  a_rel: assert property (p_rel) else $error("release off period start");
  property p_rd;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule
`default_nettype wire

/* File: dv/pas_bridge_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pas_bridge_model
  import pas_pkg::*;
(
  // pins from the block
  input wire pas_pins_t out_i,
  input wire pas_pins_t oe_i,
  // gate level at each switch driver
  output pas_pins_t gate_o
);
  assign gate_o = out_i & oe_i;
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import pas_pkg::*;;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mode = 1'b1;
  logic per = 1'b0;
  logic xen = 1'b1;
  logic [2:0] src = 3'h0;
  pas_pins_t lvl = 4'hf;
  pas_pins_t oe = 4'hf;
  pas_pins_t bout;
  pas_pins_t pin_oe;
  pas_pins_t pins;
  logic [7:0] rdata;
  logic shut;
  logic irq;
  int error_cnt = 0;
  int checks_done = 0;
  pas_auto_shutdown dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pwm_mode_i(mode), .period_start_i(per), .pwm_level_i(lvl), .pwm_oe_i(oe),
    .external_irq_zero_enable_i(xen), .cmp1_i(src[0]), .cmp2_i(src[1]),
    .external_irq_zero_i(src[2]), .bridge_out_o(bout), .bridge_oe_o(pin_oe),
    .shutdown_active_o(shut), .irq_o(irq));
  pas_bridge_model drv (.out_i(bout), .oe_i(pin_oe), .gate_o(pins));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask
  // half-cycle source pulse: never synchronised, so only the gate acts
  task automatic pulse(input int j, input logic e);
    @(posedge clock_i);
    src <= 3'(1 << j);
    #1;
    chk("pins", {3'h0, shut, pins}, e ? 8'h10 : 8'h0f);
    @(negedge clock_i);
    src <= 3'h0;
  endtask
  // {oe a,b,c,d, level a,b,c,d} for the two state fields
  function automatic logic [7:0] exp_pins(logic [1:0] ac, logic [1:0] bd);
    logic ea;
    logic eb;
    ea = !ac[1];
    eb = !bd[1];
    return {ea, eb, ea, eb, ea & ac[0], eb & bd[0], ea & ac[0], eb & bd[0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    wr_reg(2'h3, 8'hff);
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h1, 8'h00);
    rd_reg(2'h2, 8'h00);
    rd_reg(2'h3, 8'h00);
    $display("test reset done");
    wr_reg(2'h2, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr_reg(2'h0, {4'h8, 2'(c), 2'(c ^ 1)});
      #1;
      chk("pin states", {pin_oe, pins}, exp_pins(2'(c), 2'(c ^ 1)));
    end
    chk("irq", {7'h0, irq}, 8'h01);
    wr_reg(2'h0, 8'h00);
    #1;
    chk("held", {7'h0, shut}, 8'h01);
    @(posedge clock_i);
    per <= 1'b1;
    @(posedge clock_i);
    per <= 1'b0;
    @(posedge clock_i);
    #1;
    chk("released", {7'h0, shut}, 8'h00);
    rd_reg(2'h1, 8'h06);
    rd_reg(2'h1, 8'h00);
    chk("irq", {7'h0, irq}, 8'h00);
    $display("test software shutdown done");
    for (int s = 0; s < 8; s++) begin
      wr_reg(2'h0, {1'b0, 3'(s), 4'h0});
      for (int j = 0; j < 3; j++) begin
        pulse(j, s[j]);
      end
    end
    @(posedge clock_i);
    xen <= 1'b0;
    pulse(2, 1'b0);
    @(posedge clock_i);
    xen <= 1'b1;
    mode <= 1'b0;
    pulse(0, 1'b0);
    @(posedge clock_i);
    mode <= 1'b1;
    $display("test source select done");
    wr_reg(2'h0, 8'h50);
    @(posedge clock_i);
    src <= 3'h5;
    repeat (4) @(posedge clock_i);
    src <= 3'h0;
    rd_reg(2'h0, 8'hd0);
    chk("latched", {irq, 6'h0, shut}, 8'h01);
    @(posedge clock_i);
    src <= 3'h1;
    repeat (3) @(posedge clock_i);
    wr_reg(2'h0, 8'h50);
    rd_reg(2'h0, 8'hd0);
    src <= 3'h0;
    repeat (3) @(posedge clock_i);
    wr_reg(2'h0, 8'h50);
    rd_reg(2'h0, 8'h50);
    wr_reg(2'h2, 8'h01);
    repeat (2) @(posedge clock_i);
    #1;
    chk("irq", {7'h0, irq}, 8'h01);
    $display("test hardware shutdown done");
    stop_test();
  end
endmodule
bind pas_auto_shutdown pas_sva #(.ADDR_W(ADDR_W)) u_sva (.clock_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pwm_mode_i, .period_start_i,
  .pwm_level_i, .pwm_oe_i, .external_irq_zero_enable_i, .cmp1_i, .external_irq_zero_i,
  .bridge_out_o, .bridge_oe_o, .shutdown_active_o);
`default_nettype wire
